// >>> shared/tdg_pkg.sv
package tdg_pkg;

    // ----------------------------------------------------------------
    // Clock, reference and timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          CLK_MHZ      = 25;
    localparam int          REF_HZ       = 3_579_545;
    localparam int          REF_DIV      = 2;
    localparam int          NCO_W        = 16;
    localparam logic [15:0] NCO_INC      =
        16'((longint'(REF_HZ) * 65536 + longint'(CLK_HZ / 2)) / longint'(CLK_HZ));
    localparam int          SETTLE_NS    = 2000;
    localparam int          SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int          SETTLE_W     = 8;

    // ----------------------------------------------------------------
    // Keypad and synthesis geometry
    // ----------------------------------------------------------------
    localparam int          N_ROWS       = 4;
    localparam int          N_COLS       = 4;
    localparam int          OVERSAMPLE   = 16;
    localparam int          RATIO_W      = 8;
    localparam int          JOHN_W       = 8;
    localparam int          SEG_W        = 5;
    localparam int          LVL_W        = 4;
    localparam int          TONE_W       = 5;
    localparam logic [1:0]  LAST_COL     = 2'h3;

    typedef enum logic [2:0] {
        SC_IDLE,
        SC_ROWS,
        SC_COL,
        SC_ALONE,
        SC_CHECK
    } tdg_scan_t;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int tdg_low_hz(input logic [1:0] idx);
        case (idx)
            2'h0:    return 697;
            2'h1:    return 770;
            2'h2:    return 852;
            default: return 941;
        endcase
    endfunction : tdg_low_hz

    function automatic int tdg_high_hz(input logic [1:0] idx);
        case (idx)
            2'h0:    return 1209;
            2'h1:    return 1336;
            2'h2:    return 1477;
            default: return 1633;
        endcase
    endfunction : tdg_high_hz

    // Half reference over sixteen times the tone, rounded to nearest
    function automatic logic [RATIO_W-1:0] tdg_ratio(input int hz);
        int r;
        r = (REF_HZ + hz * OVERSAMPLE) / (hz * OVERSAMPLE * REF_DIV);
        return RATIO_W'(r);
    endfunction : tdg_ratio

    function automatic logic [2:0] tdg_pop4(input logic [3:0] v);
        return 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]});
    endfunction : tdg_pop4

    function automatic logic [1:0] tdg_idx4(input logic [3:0] v);
        if (v[0]) begin
            return 2'h0;
        end else if (v[1]) begin
            return 2'h1;
        end else if (v[2]) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction : tdg_idx4

    // Stairstep sine level for one of 32 segments
    function automatic logic [LVL_W-1:0] tdg_sine_lvl(input logic [SEG_W-1:0] seg);
        logic [2:0]       q;
        logic [LVL_W-1:0] a;
        q = seg[3] ? ~seg[2:0] : seg[2:0];
        case (q)
            3'h0:    a = 4'h8;
            3'h1:    a = 4'hA;
            3'h2:    a = 4'hB;
            3'h3:    a = 4'hC;
            3'h4:    a = 4'hD;
            3'h5:    a = 4'hE;
            default: a = 4'hF;
        endcase
        return seg[4] ? 4'(4'hF - a) : a;
    endfunction : tdg_sine_lvl

endpackage : tdg_pkg

// >>> shared/tdg_tone_if.sv
`timescale 1ns/1ps
interface tdg_tone_if;
    import tdg_pkg::*;
    logic                 run;
    logic                 half_tick;
    logic [RATIO_W-1:0]   ratio;
    logic [SEG_W-1:0]     seg;

    modport ctrl (output run, output half_tick, output ratio, input seg);
    modport gen  (input run, input half_tick, input ratio, output seg);
endinterface : tdg_tone_if

// >>> verilog/tdg_ref_osc.sv
`timescale 1ns/1ps
module tdg_ref_osc
    import tdg_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic run_i,
    output logic      half_tick_o,
    output logic      running_o
);

    logic [NCO_W-1:0] acc;
    logic             ref_phase;
    logic [NCO_W:0]   sum;

    assign sum = {1'b0, acc} + {1'b0, NCO_INC};

    // ----------------------------------------------------------------
    // Reference synthesis, stopped while not running
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !run_i) begin
            acc         <= '0;
            ref_phase   <= 1'b0;
            half_tick_o <= 1'b0;
        end else begin
            acc         <= sum[NCO_W-1:0];
            half_tick_o <= sum[NCO_W] & ref_phase;       // see R06
            if (sum[NCO_W]) begin
                ref_phase <= ~ref_phase;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            running_o <= 1'b0;
        end else begin
            running_o <= run_i;                          // see R05
        end
    end

endmodule : tdg_ref_osc

// >>> verilog/tdg_tone_div.sv
`timescale 1ns/1ps
module tdg_tone_div
    import tdg_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    tdg_tone_if.gen   tone
);

    logic [RATIO_W-1:0] cnt;
    logic [JOHN_W-1:0]  john;
    logic               phase;
    logic [3:0]         jidx;
    logic [3:0]         jpop;

    // ----------------------------------------------------------------
    // Programmable divider and Johnson counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !tone.run) begin
            cnt   <= '0;
            john  <= '0;
            phase <= 1'b0;
        end else if (tone.half_tick) begin
            if (cnt >= RATIO_W'(tone.ratio - 8'h01)) begin
                cnt   <= '0;
                john  <= {john[JOHN_W-2:0], ~john[JOHN_W-1]}; // see R11
                phase <= 1'b0;
            end else begin
                cnt <= RATIO_W'(cnt + 8'h01);                 // see R10
                if (RATIO_W'(cnt + 8'h01) == {1'b0, tone.ratio[RATIO_W-1:1]}) begin
                    phase <= 1'b1;                            // see R11
                end
            end
        end
    end

    assign jpop = 4'({1'b0, tdg_pop4(john[3:0])} + {1'b0, tdg_pop4(john[7:4])});
    assign jidx = john[JOHN_W-1] ? 4'(5'h10 - {1'b0, jpop}) : jpop;
    assign tone.seg = {jidx, phase};

endmodule : tdg_tone_div

// >>> verilog/tdg_dual_tone_keypad.sv
`timescale 1ns/1ps
// Contract
// R01 - Low group tones 697, 770, 852, 941 Hz, one per row.
// R02 - High group tones 1209, 1336, 1477, 1633 Hz, one per column.
// R03 - Active row picks low tone, active column picks high tone.
// R04 - Standard keypads leave the fourth column unused.
// R05 - Reference oscillator runs only while a row is active; here it runs from the first high row until a check step finds no row.
// R06 - Reference is halved, then feeds separate low and high dividers.
// R07 - Idle: pull-downs on all rows, pull-ups on all columns.
// R08 - High row starts oscillator and scan; scan switches pulls to find key.
// R09 - Driving logic must be active high; series diodes advised.
// R10 - Valid key loads dividers to run at sixteen times the tone.
// R11 - Divider drives eight-stage Johnson counter on both edges, 32 segments.
// R12 - Divider ratios keep every tone within 0.75 percent.
// R13 - One row plus one column gives dual tone; diagonal keys give none.
// R14 - Lone row or two keys in one row gives low tone only.
// R15 - Two keys in one column gives high tone only.
// R16 - Mode select low blocks single tones; high allows both.
// R17 - Disable: tone low, lines float, oscillator stops, line outputs idle.
// R18 - Idle: silence low, hold sourcing; key down: silence high, hold floats.
// R19 - Disable forces silence low and hold active regardless of keypad.
// R20 - Ratio is rounded half reference over sixteen tone, chosen from decode.
module tdg_dual_tone_keypad
    import tdg_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic [N_ROWS-1:0] row_line_i,
    input  wire logic [N_COLS-1:0] column_line_i,
    input  wire logic              tone_mode_select_i,
    input  wire logic              chip_disable_i,
    output logic      [N_ROWS-1:0] row_pd_en_o,
    output logic      [N_COLS-1:0] column_pu_en_o,
    output logic                   osc_run_o,
    output logic      [TONE_W-1:0] tone_o,
    output logic                   mute_o,
    output logic                   transmit_hold_out_o,
    output logic                   transmit_hold_out_oe_o,
    output logic                   low_active_o,
    output logic                   high_active_o
);

    tdg_scan_t            state;
    logic [SETTLE_W-1:0]  settle;
    logic                 settled;
    logic [1:0]           col_sel;
    logic [N_ROWS-1:0]    key_mat [N_COLS];
    logic [N_ROWS-1:0]    alone_rows;
    logic [N_ROWS-1:0]    rows_seen;

    logic                 low_en;
    logic                 high_en;
    logic [1:0]           low_idx;
    logic [1:0]           high_idx;

    logic [N_COLS-1:0]    cols_hit;
    logic [N_ROWS-1:0]    key_rows;
    logic [N_ROWS-1:0]    alone_sel;
    logic [4:0]           key_cnt;
    logic                 next_dual;
    logic                 next_low_only;
    logic                 next_high_only;
    logic                 osc_req;
    logic                 osc_running;
    logic                 half_tick;

    tdg_tone_if low_tone ();
    tdg_tone_if high_tone ();

    assign settled = (settle == SETTLE_W'(SETTLE_CYC - 1));
    assign osc_req = (state != SC_IDLE) && !chip_disable_i;             // see R05

    // ----------------------------------------------------------------
    // Reference oscillator and group dividers
    // ----------------------------------------------------------------
    tdg_ref_osc u_ref_osc (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .run_i       (osc_req),
        .half_tick_o (half_tick),
        .running_o   (osc_running)
    );

    assign low_tone.run        = low_en && osc_running;
    assign high_tone.run       = high_en && osc_running;
    assign low_tone.half_tick  = half_tick;                             // see R06
    assign high_tone.half_tick = half_tick;                             // see R06
    assign low_tone.ratio      = tdg_ratio(tdg_low_hz(low_idx));       // see R01, R12, R20
    assign high_tone.ratio     = tdg_ratio(tdg_high_hz(high_idx));     // see R02, R12, R20

    tdg_tone_div u_low_div (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .tone      (low_tone.gen)
    );

    tdg_tone_div u_high_div (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .tone      (high_tone.gen)
    );

    // ----------------------------------------------------------------
    // Scan sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i) begin
            state   <= SC_IDLE;
            col_sel <= 2'h0;
        end else begin
            case (state)
                SC_IDLE: begin
                    if (|row_line_i) begin
                        state <= SC_ROWS;                               // see R08
                    end
                end
                SC_ROWS: begin
                    if (settled) begin
                        state   <= SC_COL;
                        col_sel <= 2'h0;
                    end
                end
                SC_COL: begin
                    if (settled) begin
                        if (col_sel == LAST_COL) begin
                            state <= SC_ALONE;
                        end else begin
                            col_sel <= 2'(col_sel + 2'h1);
                        end
                    end
                end
                SC_ALONE: begin
                    if (settled) begin
                        state <= SC_CHECK;
                    end
                end
                SC_CHECK: begin
                    if (settled) begin
                        if (|row_line_i) begin
                            state   <= SC_COL;
                            col_sel <= 2'h0;
                        end else begin
                            state <= SC_IDLE;
                        end
                    end
                end
                default: begin
                    state <= SC_IDLE;
                end
            endcase
        end
    end

    // Settling time after each change of the pull pattern
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i || state == SC_IDLE || settled) begin
            settle <= '0;
        end else begin
            settle <= SETTLE_W'(settle + 8'h01);
        end
    end

    // ----------------------------------------------------------------
    // Pull resistor control
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            row_pd_en_o    <= '1;
            column_pu_en_o <= '1;
        end else if (chip_disable_i) begin
            row_pd_en_o    <= '0;                                       // see R17
            column_pu_en_o <= '0;                                       // see R17
        end else begin
            row_pd_en_o <= '1;
            case (state)
                SC_COL: begin
                    column_pu_en_o <= 4'h1 << col_sel;                  // see R08
                end
                SC_ALONE: begin
                    column_pu_en_o <= '0;                               // see R08
                end
                default: begin
                    column_pu_en_o <= '1;                               // see R07
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sampling of the keypad
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i || state == SC_IDLE) begin
            for (int c = 0; c < N_COLS; c++) begin
                key_mat[c] <= '0;
            end
            alone_rows <= '0;
            rows_seen  <= '0;
        end else if (settled) begin
            case (state)
                SC_ROWS: begin
                    rows_seen <= row_line_i;
                end
                SC_COL: begin
                    key_mat[col_sel] <= row_line_i;                     // see R08
                end
                SC_ALONE: begin
                    alone_rows <= row_line_i;
                end
                default: begin
                    rows_seen <= rows_seen;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Key decode
    // ----------------------------------------------------------------
    always_comb begin
        // Logic-held rows are not keys
        alone_sel = (state == SC_ALONE) ? row_line_i : alone_rows;
        cols_hit  = '0;
        key_rows = '0;
        key_cnt  = '0;
        for (int c = 0; c < N_COLS; c++) begin
            cols_hit[c] = |(key_mat[c] & ~alone_sel);
            key_rows    = key_rows | (key_mat[c] & ~alone_sel);
            key_cnt     = 5'(key_cnt + {2'h0, tdg_pop4(key_mat[c] & ~alone_sel)});
        end
    end

    always_comb begin
        next_dual      = (tdg_pop4(key_rows) == 3'h1) && (tdg_pop4(cols_hit) == 3'h1)
                         && (key_cnt == 5'h01) && (alone_sel == '0);    // see R03, R13
        next_low_only  = ((tdg_pop4(alone_sel) == 3'h1) && (cols_hit == '0))
                         || ((tdg_pop4(key_rows) == 3'h1)
                         && (tdg_pop4(cols_hit) == 3'h2));              // see R14
        next_high_only = (tdg_pop4(cols_hit) == 3'h1)
                         && (tdg_pop4(key_rows) == 3'h2)
                         && (alone_sel == '0);                          // see R15
    end

    // Result taken after the full pass, held until the next pass ends
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i || state == SC_IDLE) begin
            low_en   <= 1'b0;
            high_en  <= 1'b0;
            low_idx  <= 2'h0;
            high_idx <= 2'h0;
        end else if (state == SC_ALONE && settled) begin
            low_en   <= next_dual
                        || (next_low_only && tone_mode_select_i);       // see R13, R16
            high_en  <= next_dual
                        || (next_high_only && tone_mode_select_i);      // see R13, R16
            low_idx  <= next_low_only && (cols_hit == '0)
                        ? tdg_idx4(alone_sel) : tdg_idx4(key_rows);     // see R03
            high_idx <= tdg_idx4(cols_hit);                             // see R03
        end
    end

    // ----------------------------------------------------------------
    // Tone summation
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i) begin
            tone_o <= '0;                                               // see R17
        end else begin
            tone_o <= TONE_W'((low_tone.run ? {1'b0, tdg_sine_lvl(low_tone.seg)} : 5'h00)
                    + (high_tone.run ? {1'b0, tdg_sine_lvl(high_tone.seg)} : 5'h00));
        end
    end

    // ----------------------------------------------------------------
    // Line control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || chip_disable_i) begin
            mute_o                 <= 1'b0;                             // see R19
            transmit_hold_out_oe_o <= 1'b1;                             // see R17, R19
        end else begin
            mute_o                 <= state != SC_IDLE;                 // see R18
            transmit_hold_out_oe_o <= state == SC_IDLE;                 // see R18
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            osc_run_o     <= 1'b0;
            low_active_o  <= 1'b0;
            high_active_o <= 1'b0;
        end else begin
            osc_run_o     <= osc_req;                                   // see R05, R17
            low_active_o  <= low_tone.run;
            high_active_o <= high_tone.run;
        end
    end

    assign transmit_hold_out_o = 1'b1;

endmodule : tdg_dual_tone_keypad

// >>> verif/tdg_keypad_asserts.sv
`timescale 1ns/1ps
module tdg_keypad_asserts
    import tdg_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              srst_i,
    input wire logic [N_ROWS-1:0] row_line_i,
    input wire logic [N_COLS-1:0] column_line_i,
    input wire logic              tone_mode_select_i,
    input wire logic              chip_disable_i,
    input wire logic [N_ROWS-1:0] row_pd_en_o,
    input wire logic [N_COLS-1:0] column_pu_en_o,
    input wire logic              osc_run_o,
    input wire logic [TONE_W-1:0] tone_o,
    input wire logic              mute_o,
    input wire logic              transmit_hold_out_o,
    input wire logic              transmit_hold_out_oe_o,
    input wire logic              low_active_o,
    input wire logic              high_active_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    sequence s_row_seen;
        !osc_run_o && !chip_disable_i && (|row_line_i) ##1 !chip_disable_i;
    endsequence
    sequence s_single_step;
        $changed(tone_o) && (low_active_o ^ high_active_o);
    endsequence

    property p_idle_pulls;
        !chip_disable_i && !$past(chip_disable_i) && !osc_run_o
            |-> row_pd_en_o == 4'hF && column_pu_en_o == 4'hF;
    endproperty
    property p_start;
        s_row_seen |-> ##1 osc_run_o && mute_o;
    endproperty
    property p_disable_clear;
        chip_disable_i |=> tone_o == 5'h00 && !osc_run_o && row_pd_en_o == 4'h0
            && column_pu_en_o == 4'h0;
    endproperty
    property p_disable_lines;
        chip_disable_i |=> !mute_o && transmit_hold_out_oe_o;
    endproperty
    property p_hold_vs_mute;
        transmit_hold_out_o && (mute_o != transmit_hold_out_oe_o);
    endproperty
    property p_stopped_quiet;
        !osc_run_o && !$past(osc_run_o) |-> tone_o == 5'h00 && !mute_o
            && !low_active_o && !high_active_o;
    endproperty
    property p_single_mode;
        $rose(low_active_o ^ high_active_o) |-> $past(tone_mode_select_i);
    endproperty
    property p_seg_hold;
        s_single_step |=> ($stable(tone_o) || !(low_active_o ^ high_active_o)) [*8];
    endproperty

    a_idle_pulls: assert property (p_idle_pulls) else $error("pulls not idle");
    a_start: assert property (p_start) else $error("scan did not start");
    a_disable_clear: assert property (p_disable_clear) else $error("disable left activity");
    a_disable_lines: assert property (p_disable_lines) else $error("disable line outputs");
    a_hold_vs_mute: assert property (p_hold_vs_mute) else $error("hold and mute disagree");
    a_stopped_quiet: assert property (p_stopped_quiet) else $error("tone while stopped");
    a_single_mode: assert property (p_single_mode) else $error("single tone while blocked");
    a_seg_hold: assert property (p_seg_hold) else $error("segment too short");
endmodule : tdg_keypad_asserts

// >>> verif/tdg_keypad_model.sv
`timescale 1ns/1ps
module tdg_keypad_model
    import tdg_pkg::*;
(
    input  wire logic [15:0]       keys_i,
    input  wire logic [N_ROWS-1:0] logic_row_i,
    input  wire logic              clk_sys_i,
    input  wire logic [N_ROWS-1:0] row_pd_en_i,
    input  wire logic [N_COLS-1:0] column_pu_en_i,
    output logic      [N_ROWS-1:0] row_line_o,
    output logic      [N_COLS-1:0] column_line_o
);
    logic flip = 1'b0;

    // Undriven lines show a pattern that changes every cycle
    always @(posedge clk_sys_i) flip <= ~flip;

    // Key bit r*4+c joins row r to column c; fourth column fitted
    always_comb begin
        for (int r = 0; r < N_ROWS; r++) begin
            row_line_o[r] = logic_row_i[r] | (|(keys_i[r*4 +: 4] & column_pu_en_i))
                            | (~row_pd_en_i[r] & flip);
        end
        for (int c = 0; c < N_COLS; c++) begin
            column_line_o[c] = column_pu_en_i[c] | flip;
        end
    end
endmodule : tdg_keypad_model

// >>> verif/tdg_dual_tone_keypad_tb.sv
`timescale 1ns/1ps
module tdg_dual_tone_keypad_tb;
    import tdg_pkg::*;
    logic              clk_sys_i, srst_i, tone_mode_select_i, chip_disable_i;
    logic [N_ROWS-1:0] row_line_i, row_pd_en_o, logic_row;
    logic [N_COLS-1:0] column_line_i, column_pu_en_o;
    logic [15:0]       keys;
    logic [TONE_W-1:0] tone_o;
    logic              osc_run_o, mute_o, transmit_hold_out_o, transmit_hold_out_oe_o;
    logic              low_active_o, high_active_o;
    int                mismatches = 0;
    int                n_tests = 0;

    tdg_dual_tone_keypad i_tdg_dual_tone_keypad (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .row_line_i(row_line_i), .column_line_i(column_line_i),
        .tone_mode_select_i(tone_mode_select_i), .chip_disable_i(chip_disable_i),
        .row_pd_en_o(row_pd_en_o), .column_pu_en_o(column_pu_en_o), .osc_run_o(osc_run_o),
        .tone_o(tone_o), .mute_o(mute_o), .transmit_hold_out_o(transmit_hold_out_o),
        .transmit_hold_out_oe_o(transmit_hold_out_oe_o), .low_active_o(low_active_o),
        .high_active_o(high_active_o));
    tdg_keypad_model i_tdg_keypad_model (.keys_i(keys), .logic_row_i(logic_row),
        .clk_sys_i(clk_sys_i), .row_pd_en_i(row_pd_en_o), .column_pu_en_i(column_pu_en_o),
        .row_line_o(row_line_i), .column_line_o(column_line_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Apply keys, wait one full scan pass, then compare group activity
    task automatic press(input logic [15:0] k, input logic [3:0] lr, input logic lo,
                         input logic hi);
        @(negedge clk_sys_i);
        keys = k;
        logic_row = lr;
        repeat (320) @(negedge clk_sys_i);
        check("low_active", {7'h00, lo}, {7'h00, low_active_o});
        check("high_active", {7'h00, hi}, {7'h00, high_active_o});
        check("mute", 8'h01, {7'h00, mute_o});
    endtask : press

    task automatic release_all(input string name);
        int n;
        n = 0;
        keys = '0;
        logic_row = '0;
        while (osc_run_o !== 1'b0 && n < 1000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("release", 8'h00, {7'h00, osc_run_o});
        @(negedge clk_sys_i);
        check("pulls", 8'hFF, {row_pd_en_o, column_pu_en_o});
        check("hold_oe", 8'h01, {7'h00, transmit_hold_out_oe_o});
        $display("test %s done", name);
    endtask : release_all

    // Time between mid-level crossings is half a tone period
    task automatic measure(input int hz);
        int n, ex;
        logic up;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            up = tone_o >= 5'h08;
            while ((tone_o >= 5'h08) === up && n < 40000) begin
                @(negedge clk_sys_i);
                n++;
            end
        end
        ex = CLK_HZ / (2 * hz);
        n_tests++;
        if (n < ex - ex * 3 / 400 - 16 || n > ex + ex * 3 / 400 + 16) begin
            mismatches++;
            $display("[FAIL] half period expected %0d seen %0d", ex, n);
        end
    endtask : measure

    initial begin
        srst_i = 1'b1;
        chip_disable_i = 1'b0;
        tone_mode_select_i = 1'b1;
        keys = '0;
        logic_row = '0;
        repeat (6) @(negedge clk_sys_i);
        srst_i = 1'b0;
        @(negedge clk_sys_i);
        check("osc_run", 8'h00, {7'h00, osc_run_o});
        release_all("reset");
        for (int r = 0; r < 4; r++) begin
            press(16'h0001 << (r * 5), 4'h0, 1'b1, 1'b1);
            release_all("dual");
        end
        press(16'h0021, 4'h0, 1'b0, 1'b0);
        release_all("diagonal");
        press(16'h0003, 4'h0, 1'b1, 1'b0);
        release_all("row pair");
        press(16'h0000, 4'h8, 1'b1, 1'b0);
        measure(941);
        release_all("row alone");
        press(16'h0088, 4'h0, 1'b0, 1'b1);
        measure(1633);
        release_all("column pair");
        tone_mode_select_i = 1'b0;
        press(16'h0000, 4'h1, 1'b0, 1'b0);
        release_all("blocked single");
        press(16'h0400, 4'h0, 1'b1, 1'b1);
        release_all("mode dual");
        tone_mode_select_i = 1'b1;
        press(16'h0010, 4'h0, 1'b1, 1'b1);
        chip_disable_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("disable pulls", 8'h00, {row_pd_en_o, column_pu_en_o});
        check("disable tone", 8'h00, {3'h0, tone_o});
        check("disable lines", 8'h01, {6'h00, mute_o, transmit_hold_out_oe_o});
        keys = '0;
        @(negedge clk_sys_i);
        chip_disable_i = 1'b0;
        release_all("disable");
        give_verdict();
    end

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        mismatches++;
        give_verdict();
    end
endmodule : tdg_dual_tone_keypad_tb

bind tdg_dual_tone_keypad tdg_keypad_asserts i_tdg_keypad_asserts (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .row_line_i(row_line_i), .column_line_i(column_line_i),
    .tone_mode_select_i(tone_mode_select_i), .chip_disable_i(chip_disable_i),
    .row_pd_en_o(row_pd_en_o), .column_pu_en_o(column_pu_en_o), .osc_run_o(osc_run_o),
    .tone_o(tone_o), .mute_o(mute_o), .transmit_hold_out_o(transmit_hold_out_o),
    .transmit_hold_out_oe_o(transmit_hold_out_oe_o), .low_active_o(low_active_o),
    .high_active_o(high_active_o));
